// File: core/pbsp_pkg.sv
// How it works
// - all inputs except output_drive_n, and read data, registered
// - clock_gate_n high freezes every internal state except the sleep synchroniser and asleep
// - load, selects active, strobe high starts read
// - read word appears one edge later
// - output_drive_n high gates data drivers
// - deselect releases outputs after next edge
// - burst counter gives four accesses per address
// - mode low linear, high interleaved
// - only two low address bits wrap
// - advance ignores selects and write strobe
// - direction latched at burst load
// - load, selects active, strobe low starts write
// - edge after write start forces high impedance
// - next operation accepted during write data cycle
// - write data latched second edge after start
// - only enabled byte lanes are written
// - controller drives data only when memory released
// - controller drives lane enables every burst beat
// - sleep_request high sleeps, contents kept
// - sleep entry and exit take two cycles
// - controller deselects around sleep and recovery
// - after reset deselected, outputs released
package pbsp_pkg;
  localparam int ADDR_W = 6;
  localparam int DEPTH = 64;
  localparam int LANES = 4;
  localparam int BYTE_W = 8;
  localparam int DATA_W = LANES * BYTE_W;
  localparam int LANE_W = BYTE_W + 1;
  localparam int WORD_W = LANES * LANE_W;
  localparam int BURST_W = 2;
  localparam logic [BURST_W-1:0] BURST_CNT_RST = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
  localparam logic MODE_LINEAR = 1'b0;
  localparam logic MODE_INTERLEAVED = 1'b1;
  localparam int SLEEP_SYNC_STAGES = 2;
  localparam int CLK_PERIOD_NS = 5;
  // sleep_recovery_time is two clock periods
  localparam int SLEEP_RECOVERY_TCYC = 2;
  localparam int SLEEP_RECOVERY_TIME_NS = SLEEP_RECOVERY_TCYC * CLK_PERIOD_NS;
  localparam int SLEEP_RECOVERY_CYC_I = (SLEEP_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REC_CNT_W = 2;
  localparam logic [REC_CNT_W-1:0] SLEEP_RECOVERY_CYC = REC_CNT_W'(SLEEP_RECOVERY_CYC_I);
  localparam logic [REC_CNT_W-1:0] REC_CNT_RST = 2'h0;
  localparam logic [REC_CNT_W-1:0] REC_CNT_STEP = 2'h1;

  typedef enum logic [1:0] {
    PBSP_OP_NONE = 2'b00,
    PBSP_OP_READ = 2'b01,
    PBSP_OP_WRITE = 2'b10
  } pbsp_op_t;

  typedef enum logic [1:0] {
    PBSP_HS_IDLE = 2'b00,
    PBSP_HS_ASLEEP = 2'b01,
    PBSP_HS_RECOVER = 2'b10
  } pbsp_hstate_t;
endpackage : pbsp_pkg

// File: core/pbsp_bus_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pbsp_bus_if (
  input wire logic clk
);
  logic clock_gate_n;
  logic chip_sel_first_n;
  logic chip_sel_second;
  logic chip_sel_third_n;
  logic advance_or_load;
  logic write_strobe_n;
  logic [pbsp_pkg::LANES-1:0] byte_lane_write_n;
  logic [pbsp_pkg::ADDR_W-1:0] addr_lines;
  logic burst_mode;
  logic output_drive_n;
  logic sleep_request;
  logic [pbsp_pkg::DATA_W-1:0] dev_data;
  logic [pbsp_pkg::LANES-1:0] dev_parity;
  logic dev_drive;
  logic [pbsp_pkg::DATA_W-1:0] host_data;
  logic [pbsp_pkg::LANES-1:0] host_parity;
  logic host_drive;
  logic [pbsp_pkg::DATA_W-1:0] data_lines;
  logic [pbsp_pkg::LANES-1:0] parity_lines;

  // shared wire level; an undriven bus reads as zero
  assign data_lines = dev_drive ? dev_data : (host_drive ? host_data : '0);
  assign parity_lines = dev_drive ? dev_parity : (host_drive ? host_parity : '0);

  modport dev (
    input clock_gate_n, chip_sel_first_n, chip_sel_second, chip_sel_third_n,
    input advance_or_load, write_strobe_n, byte_lane_write_n, addr_lines,
    input burst_mode, output_drive_n, sleep_request, data_lines, parity_lines,
    output dev_data, dev_parity, dev_drive
  );
  modport host (
    output clock_gate_n, chip_sel_first_n, chip_sel_second, chip_sel_third_n,
    output advance_or_load, write_strobe_n, byte_lane_write_n, addr_lines,
    output burst_mode, output_drive_n, sleep_request,
    output host_data, host_parity, host_drive,
    input data_lines, parity_lines
  );
endinterface : pbsp_bus_if
`default_nettype wire

// File: core/pbsp_burst_order.sv
`timescale 1ns/10ps
`default_nettype none
module pbsp_burst_order (
  // burst start and step
  input wire logic [pbsp_pkg::BURST_W-1:0] start_low,
  input wire logic [pbsp_pkg::BURST_W-1:0] step,
  input wire logic mode,
  // effective low address bits
  output logic [pbsp_pkg::BURST_W-1:0] eff_low
);
  wire [pbsp_pkg::BURST_W-1:0] linear_low = start_low + step;
  wire [pbsp_pkg::BURST_W-1:0] inter_low = start_low ^ step;

  assign eff_low = (mode == pbsp_pkg::MODE_INTERLEAVED) ? inter_low : linear_low;
endmodule : pbsp_burst_order
`default_nettype wire

// File: core/pbsp_device.sv
`timescale 1ns/10ps
`default_nettype none
module pbsp_device (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // memory pins
  pbsp_bus_if.dev bus,
  // status
  output logic asleep
);
  // sleep synchroniser, first stage read only by the second
  logic sleep_meta;
  logic sleep_sync;

  // burst state
  logic active;
  logic dir_write;
  logic [pbsp_pkg::ADDR_W-1:0] base_addr;
  logic [pbsp_pkg::BURST_W-1:0] burst_cnt;

  // operation sampled at the last qualified edge
  pbsp_pkg::pbsp_op_t op_kind;
  logic [pbsp_pkg::ADDR_W-1:0] op_addr;
  logic [pbsp_pkg::LANES-1:0] op_lanes_n;

  // write waiting for its data edge
  logic wr_pend;
  logic [pbsp_pkg::ADDR_W-1:0] wr_addr;
  logic [pbsp_pkg::LANES-1:0] wr_lanes_n;

  // output register
  logic rd_valid;
  logic [pbsp_pkg::WORD_W-1:0] rd_word;

  // storage
  logic [pbsp_pkg::WORD_W-1:0] mem [pbsp_pkg::DEPTH];

  wire run;
  wire selected;
  wire load;
  wire [pbsp_pkg::BURST_W-1:0] next_cnt;
  wire [pbsp_pkg::BURST_W-1:0] adv_low;
  wire [pbsp_pkg::ADDR_W-1:0] adv_addr;
  wire [pbsp_pkg::WORD_W-1:0] bus_word;
  wire [pbsp_pkg::WORD_W-1:0] mem_word;
  wire [pbsp_pkg::WORD_W-1:0] wr_merged;
  wire [pbsp_pkg::WORD_W-1:0] rd_merged;
  wire bypass;
  pbsp_pkg::pbsp_op_t next_op_kind;
  wire [pbsp_pkg::ADDR_W-1:0] next_op_addr;
  wire next_active;
  wire next_dir_write;

  // a gated edge holds burst, pipeline and storage; sleep clears the pipeline, storage kept
  assign run = ~bus.clock_gate_n & ~sleep_sync;

  assign selected = ~bus.chip_sel_first_n & bus.chip_sel_second & ~bus.chip_sel_third_n;
  assign load = ~bus.advance_or_load;

  assign next_cnt = burst_cnt + pbsp_pkg::BURST_STEP;

  pbsp_burst_order u_order (
    .start_low(base_addr[pbsp_pkg::BURST_W-1:0]),
    .step(next_cnt),
    .mode(bus.burst_mode),
    .eff_low(adv_low)
  );

  // upper address bits never move during a burst
  assign adv_addr = {base_addr[pbsp_pkg::ADDR_W-1:pbsp_pkg::BURST_W], adv_low};

  // selects and strobe only count on a load
  always_comb begin
    if (load) begin
      if (!selected) begin
        next_op_kind = pbsp_pkg::PBSP_OP_NONE;
      end else if (bus.write_strobe_n) begin
        next_op_kind = pbsp_pkg::PBSP_OP_READ;
      end else begin
        next_op_kind = pbsp_pkg::PBSP_OP_WRITE;
      end
    end else if (active) begin
      next_op_kind = dir_write ? pbsp_pkg::PBSP_OP_WRITE : pbsp_pkg::PBSP_OP_READ;
    end else begin
      next_op_kind = pbsp_pkg::PBSP_OP_NONE;
    end
  end

  assign next_op_addr = load ? bus.addr_lines : adv_addr;
  assign next_active = load ? selected : active;
  assign next_dir_write = load ? ~bus.write_strobe_n : dir_write;

  // asynchronous pin, two stages give the two-cycle entry and exit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sleep_meta <= 1'b0;
      sleep_sync <= 1'b0;
    end else begin
      sleep_meta <= bus.sleep_request;
      sleep_sync <= sleep_meta;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      asleep <= 1'b0;
    end else begin
      asleep <= sleep_sync;
    end
  end

  // burst register: address and direction only move on a load
  always_ff @(posedge clk) begin
    if (!rst_n || sleep_sync) begin
      active <= 1'b0;
      dir_write <= 1'b0;
      base_addr <= '0;
      burst_cnt <= pbsp_pkg::BURST_CNT_RST;
    end else if (run) begin
      active <= next_active;
      dir_write <= next_dir_write;
      if (load) begin
        base_addr <= bus.addr_lines;
        burst_cnt <= pbsp_pkg::BURST_CNT_RST;
      end else begin
        burst_cnt <= next_cnt;
      end
    end
  end

  // input register stage
  always_ff @(posedge clk) begin
    if (!rst_n || sleep_sync) begin
      op_kind <= pbsp_pkg::PBSP_OP_NONE;
      op_addr <= '0;
      op_lanes_n <= '1;
    end else if (run) begin
      op_kind <= next_op_kind;
      op_addr <= next_op_addr;
      op_lanes_n <= bus.byte_lane_write_n;
    end
  end

  // write data stage, completes one edge after the op stage
  always_ff @(posedge clk) begin
    if (!rst_n || sleep_sync) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
      wr_lanes_n <= '1;
    end else if (run) begin
      wr_pend <= (op_kind == pbsp_pkg::PBSP_OP_WRITE);
      wr_addr <= op_addr;
      wr_lanes_n <= op_lanes_n;
    end
  end

  assign mem_word = mem[op_addr];
  // a read right behind a write to the same word sees the new bytes
  assign bypass = wr_pend && (wr_addr == op_addr);

  genvar gi;
  generate
    for (gi = 0; gi < pbsp_pkg::LANES; gi = gi + 1) begin : g_lane
      wire lane_wr = ~wr_lanes_n[gi];
      assign bus_word[gi*pbsp_pkg::LANE_W +: pbsp_pkg::LANE_W] =
        {bus.parity_lines[gi], bus.data_lines[gi*pbsp_pkg::BYTE_W +: pbsp_pkg::BYTE_W]};
      assign wr_merged[gi*pbsp_pkg::LANE_W +: pbsp_pkg::LANE_W] = lane_wr ?
        bus_word[gi*pbsp_pkg::LANE_W +: pbsp_pkg::LANE_W] :
        mem[wr_addr][gi*pbsp_pkg::LANE_W +: pbsp_pkg::LANE_W];
      assign rd_merged[gi*pbsp_pkg::LANE_W +: pbsp_pkg::LANE_W] = (bypass && lane_wr) ?
        bus_word[gi*pbsp_pkg::LANE_W +: pbsp_pkg::LANE_W] :
        mem_word[gi*pbsp_pkg::LANE_W +: pbsp_pkg::LANE_W];
      assign bus.dev_data[gi*pbsp_pkg::BYTE_W +: pbsp_pkg::BYTE_W] =
        rd_word[gi*pbsp_pkg::LANE_W +: pbsp_pkg::BYTE_W];
      assign bus.dev_parity[gi] = rd_word[gi*pbsp_pkg::LANE_W + pbsp_pkg::BYTE_W];
    end
  endgenerate

  // storage keeps no reset so contents survive sleep and reset
  always_ff @(posedge clk) begin
    if (rst_n && run && wr_pend) begin
      mem[wr_addr] <= wr_merged;
    end
  end

  // output register: deselect and write both release the lines next edge
  always_ff @(posedge clk) begin
    if (!rst_n || sleep_sync) begin
      rd_valid <= 1'b0;
    end else if (run) begin
      rd_valid <= (op_kind == pbsp_pkg::PBSP_OP_READ);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_word <= '0;
    end else if (run && op_kind == pbsp_pkg::PBSP_OP_READ) begin
      rd_word <= rd_merged;
    end
  end

  // output_drive_n acts without the clock, so this enable is not registered
  assign bus.dev_drive = rd_valid & ~bus.output_drive_n;
endmodule : pbsp_device
`default_nettype wire

// File: core/pbsp_host.sv
`timescale 1ns/10ps
`default_nettype none
module pbsp_host (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // memory pins
  pbsp_bus_if.host bus,
  // user requests
  input wire logic op_valid,
  input wire logic op_load,
  input wire logic op_write,
  input wire logic [pbsp_pkg::ADDR_W-1:0] op_addr,
  input wire logic [pbsp_pkg::DATA_W-1:0] op_wdata,
  input wire logic [pbsp_pkg::LANES-1:0] op_wparity,
  input wire logic [pbsp_pkg::LANES-1:0] op_lanes_n,
  input wire logic burst_mode_sel,
  input wire logic sleep_want,
  input wire logic stall_req,
  output logic op_ready,
  // read answers
  output logic rsp_valid,
  output logic [pbsp_pkg::DATA_W-1:0] rsp_data,
  output logic [pbsp_pkg::LANES-1:0] rsp_parity
);
  pbsp_pkg::pbsp_hstate_t state;
  pbsp_pkg::pbsp_hstate_t next_state;
  logic [pbsp_pkg::REC_CNT_W-1:0] rec_cnt;
  logic h_active;
  logic h_dir_write;
  pbsp_pkg::pbsp_op_t kind0;
  pbsp_pkg::pbsp_op_t kind1;
  pbsp_pkg::pbsp_op_t kind2;
  logic [pbsp_pkg::DATA_W-1:0] wd0;
  logic [pbsp_pkg::DATA_W-1:0] wd1;
  logic [pbsp_pkg::LANES-1:0] wp0;
  logic [pbsp_pkg::LANES-1:0] wp1;
  pbsp_pkg::pbsp_op_t issue_kind;

  wire accept = op_valid & op_ready;
  // the memory skips a gated edge, so this end must skip it as well
  wire frozen = bus.clock_gate_n;
  wire pipe_empty = (kind0 == pbsp_pkg::PBSP_OP_NONE) && (kind1 == pbsp_pkg::PBSP_OP_NONE) &&
    (kind2 == pbsp_pkg::PBSP_OP_NONE);

  // mirror of the memory's burst direction tracking
  always_comb begin
    if (!accept) begin
      issue_kind = pbsp_pkg::PBSP_OP_NONE;
    end else if (op_load) begin
      issue_kind = op_write ? pbsp_pkg::PBSP_OP_WRITE : pbsp_pkg::PBSP_OP_READ;
    end else if (h_active) begin
      issue_kind = h_dir_write ? pbsp_pkg::PBSP_OP_WRITE : pbsp_pkg::PBSP_OP_READ;
    end else begin
      issue_kind = pbsp_pkg::PBSP_OP_NONE;
    end
  end

  always_comb begin
    case (state)
      pbsp_pkg::PBSP_HS_IDLE: begin
        next_state = (sleep_want && !accept && pipe_empty) ? pbsp_pkg::PBSP_HS_ASLEEP : state;
      end
      pbsp_pkg::PBSP_HS_ASLEEP: begin
        next_state = sleep_want ? state : pbsp_pkg::PBSP_HS_RECOVER;
      end
      pbsp_pkg::PBSP_HS_RECOVER: begin
        next_state = (rec_cnt == pbsp_pkg::SLEEP_RECOVERY_CYC) ? pbsp_pkg::PBSP_HS_IDLE : state;
      end
      default: begin
        next_state = pbsp_pkg::PBSP_HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= pbsp_pkg::PBSP_HS_IDLE;
      rec_cnt <= pbsp_pkg::REC_CNT_RST;
      op_ready <= 1'b0;
      bus.sleep_request <= 1'b0;
    end else begin
      state <= next_state;
      rec_cnt <= (state == pbsp_pkg::PBSP_HS_RECOVER) ? rec_cnt + pbsp_pkg::REC_CNT_STEP : pbsp_pkg::REC_CNT_RST;
      op_ready <= (next_state == pbsp_pkg::PBSP_HS_IDLE) && !sleep_want && !stall_req;
      bus.sleep_request <= (next_state == pbsp_pkg::PBSP_HS_ASLEEP);
    end
  end

  // command pins; idle cycles are deselecting loads
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus.clock_gate_n <= 1'b0;
      bus.chip_sel_first_n <= 1'b1;
      bus.chip_sel_second <= 1'b0;
      bus.chip_sel_third_n <= 1'b1;
      bus.advance_or_load <= 1'b0;
      bus.write_strobe_n <= 1'b1;
      bus.byte_lane_write_n <= '1;
      bus.addr_lines <= '0;
      bus.burst_mode <= pbsp_pkg::MODE_LINEAR;
      h_active <= 1'b0;
      h_dir_write <= 1'b0;
    end else begin
      bus.clock_gate_n <= stall_req;
      // pins hold through a gated edge so the memory sees them next time
      if (!frozen) begin
        bus.chip_sel_first_n <= ~(accept & op_load);
        bus.chip_sel_second <= accept & op_load;
        bus.chip_sel_third_n <= ~(accept & op_load);
        bus.advance_or_load <= accept & ~op_load;
        bus.write_strobe_n <= ~(accept & op_write);
        bus.byte_lane_write_n <= accept ? op_lanes_n : '1;
        bus.addr_lines <= op_addr;
        bus.burst_mode <= burst_mode_sel;
        if (!accept || op_load) begin
          h_active <= accept;
          h_dir_write <= op_write;
        end
      end
    end
  end

  // data pipeline: drive two edges after issue, sample three after
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      kind0 <= pbsp_pkg::PBSP_OP_NONE;
      kind1 <= pbsp_pkg::PBSP_OP_NONE;
      kind2 <= pbsp_pkg::PBSP_OP_NONE;
      wd0 <= '0;
      wd1 <= '0;
      wp0 <= '0;
      wp1 <= '0;
      bus.host_drive <= 1'b0;
      bus.host_data <= '0;
      bus.host_parity <= '0;
      bus.output_drive_n <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      rsp_parity <= '0;
    end else begin
      // one pulse per read even when a gated edge holds the pipeline
      rsp_valid <= !frozen && (kind2 == pbsp_pkg::PBSP_OP_READ);
      if (!frozen) begin
        kind0 <= issue_kind;
        kind1 <= kind0;
        kind2 <= kind1;
        wd0 <= op_wdata;
        wd1 <= wd0;
        wp0 <= op_wparity;
        wp1 <= wp0;
        bus.host_drive <= (kind1 == pbsp_pkg::PBSP_OP_WRITE);
        bus.output_drive_n <= (kind1 == pbsp_pkg::PBSP_OP_WRITE);
        bus.host_data <= wd1;
        bus.host_parity <= wp1;
        rsp_data <= bus.data_lines;
        rsp_parity <= bus.parity_lines;
      end
    end
  end
endmodule : pbsp_host
`default_nettype wire

// File: verif/pbsp_checker_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module pbsp_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // host controls
  input wire logic clock_gate_n,
  input wire logic chip_sel_first_n,
  input wire logic chip_sel_second,
  input wire logic chip_sel_third_n,
  input wire logic advance_or_load,
  input wire logic write_strobe_n,
  input wire logic output_drive_n,
  input wire logic sleep_request,
  // drivers and status
  input wire logic dev_drive,
  input wire logic host_drive,
  input wire logic asleep
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // an edge the device acts on
  wire logic live = !clock_gate_n && !sleep_request && !asleep;
  wire logic sel_all = !chip_sel_first_n && chip_sel_second && !chip_sel_third_n;
  wire logic ld_rd = live && !advance_or_load && sel_all && write_strobe_n;
  wire logic ld_wr = live && !advance_or_load && sel_all && !write_strobe_n;
  wire logic ld_off = live && !advance_or_load && !sel_all;
  wire logic adv = live && advance_or_load;

  // burst direction: 0 none, 1 read, 2 write; gated edges keep it
  logic [1:0] dir;
  always_ff @(posedge clk) begin
    if (!rst_n || sleep_request || asleep) begin
      dir <= 2'h0;
    end else if (live && !advance_or_load) begin
      dir <= {ld_wr, ld_rd};
    end
  end

  property p_no_clash; !(dev_drive && host_drive); endproperty
  property p_drive_gate; dev_drive |-> !output_drive_n; endproperty
  // a gated edge in between delays the outcome, so only ungated pairs count
  property p_rd_data; ld_rd ##1 !clock_gate_n |-> ##1 (dev_drive == !output_drive_n); endproperty
  property p_desel; ld_off ##1 !clock_gate_n |-> ##1 !dev_drive; endproperty
  property p_wr_float; ld_wr ##1 !clock_gate_n |-> ##1 !dev_drive; endproperty
  property p_wr_data; ld_wr ##1 !clock_gate_n |-> ##1 host_drive; endproperty
  property p_burst_rd; (adv && dir == 2'h1) ##1 !clock_gate_n |-> ##1 (dev_drive == !output_drive_n); endproperty
  property p_burst_wr; (adv && dir == 2'h2) ##1 !clock_gate_n |-> ##1 (host_drive && !dev_drive); endproperty
  property p_gate_hold; clock_gate_n |=> $stable(dev_drive) && $stable(host_drive); endproperty
  property p_reset_idle; $rose(rst_n) |-> !dev_drive; endproperty
  property p_sleep_in; $rose(sleep_request) |-> ##[2:4] asleep; endproperty
  property p_sleep_out; $fell(sleep_request) |-> ##[2:4] !asleep; endproperty
  property p_sleep_desel; (sleep_request || asleep) |-> !sel_all; endproperty

  a_no_clash: assert property (p_no_clash) else $error("both ends drive data");
  a_drive_gate: assert property (p_drive_gate) else $error("device drives while disabled");
  a_rd_data: assert property (p_rd_data) else $error("read data not driven on time");
  a_desel: assert property (p_desel) else $error("deselect did not release");
  a_wr_float: assert property (p_wr_float) else $error("device drives in write data cycle");
  a_wr_data: assert property (p_wr_data) else $error("write data not presented");
  a_burst_rd: assert property (p_burst_rd) else $error("burst read beat missing");
  a_burst_wr: assert property (p_burst_wr) else $error("burst write beat wrong");
  a_reset_idle: assert property (p_reset_idle) else $error("outputs driven after reset");
  a_sleep_in: assert property (p_sleep_in) else $error("sleep not entered in time");
  a_sleep_out: assert property (p_sleep_out) else $error("sleep not left in time");
  a_sleep_desel: assert property (p_sleep_desel) else $error("selected around sleep");
  a_gate_hold: assert property (p_gate_hold) else $error("gated edge changed a driver");

  c_write: cover property (ld_wr);
  c_burst_rd: cover property (adv && dir == 2'h1);
  c_sleep: cover property ($rose(asleep));
  c_stall: cover property (clock_gate_n);
endmodule : pbsp_checker
`default_nettype wire

// File: verif/pbsp_tb.sv
`timescale 1ns/10ps
`default_nettype none
module pbsp_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic op_valid = 1'b0;
  logic op_load = 1'b0;
  logic op_write = 1'b0;
  logic [5:0] op_addr = 6'h00;
  logic [35:0] op_word = 36'h0;
  logic [3:0] op_lanes_n = 4'hF;
  logic mode = 1'b0;
  logic sleep_want = 1'b0;
  logic stall = 1'b0;
  logic op_ready;
  logic rsp_valid;
  logic [31:0] rsp_data;
  logic [3:0] rsp_parity;
  logic asleep;
  logic [35:0] mem [64];
  logic [35:0] exp_q [$];
  logic [5:0] base;
  logic [1:0] beat;
  logic bdir;
  int failures = 0;
  int num_checks = 0;

  always #2.5 clk = ~clk;

  pbsp_bus_if bus (.clk(clk));
  pbsp_device pbsp_device_inst (.clk(clk), .rst_n(rst_n), .bus(bus.dev), .asleep(asleep));
  pbsp_host pbsp_host_inst (.clk(clk), .rst_n(rst_n), .bus(bus.host), .op_valid(op_valid), .op_load(op_load),
    .op_write(op_write), .op_addr(op_addr), .op_wdata(op_word[31:0]), .op_wparity(op_word[35:32]),
    .op_lanes_n(op_lanes_n), .burst_mode_sel(mode), .sleep_want(sleep_want), .op_ready(op_ready),
    .stall_req(stall), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_parity(rsp_parity));
  pbsp_checker pbsp_checker_inst (.clk(clk), .rst_n(rst_n), .clock_gate_n(bus.clock_gate_n),
    .chip_sel_first_n(bus.chip_sel_first_n), .chip_sel_second(bus.chip_sel_second),
    .chip_sel_third_n(bus.chip_sel_third_n), .advance_or_load(bus.advance_or_load),
    .write_strobe_n(bus.write_strobe_n), .output_drive_n(bus.output_drive_n), .sleep_request(bus.sleep_request),
    .dev_drive(bus.dev_drive), .host_drive(bus.host_drive), .asleep(asleep));

  task automatic check(input logic [35:0] exp, input logic [35:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t ns: expected %h got %h", $time, exp, got);
    end
  endtask : check

  task automatic print_verdict();
    if (failures == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // one beat; the model follows the burst order and lane mask at acceptance
  task automatic op(input logic ld, input logic wr, input logic [5:0] a, input logic [35:0] d, input logic [3:0] ln);
    int n;
    logic [5:0] ea;
    op_valid = 1'b1;
    op_load = ld;
    op_write = wr;
    op_addr = a;
    op_word = d;
    op_lanes_n = ln;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (op_ready !== 1'b1 && n < 64);
    if (n >= 64) failures++;
    if (ld) begin
      base = a;
      beat = 2'h0;
      bdir = wr;
    end else begin
      beat = beat + 2'h1;
    end
    ea = {base[5:2], mode ? (base[1:0] ^ beat) : (base[1:0] + beat)};
    for (int i = 0; i < 4; i++) begin
      if (bdir && !ln[i]) begin
        mem[ea][8*i +: 8] = d[8*i +: 8];
        mem[ea][32+i] = d[32+i];
      end
    end
    if (!bdir) exp_q.push_back(mem[ea]);
    #1;
  endtask : op

  task automatic idle(input int c);
    op_valid = 1'b0;
    repeat (c) @(posedge clk);
    #1;
  endtask : idle

  always @(posedge clk) begin
    if (rsp_valid === 1'b1) begin
      check(exp_q.size() > 0 ? exp_q.pop_front() : 36'hX, {rsp_parity, rsp_data});
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++) op(1'b1, 1'b1, 6'(i), {4'(i), 32'hA5A5_0000 + 32'(i * 257)}, 4'h0);
    for (int i = 0; i < 8; i++) op(1'b1, 1'b0, 6'(i), 36'h0, 4'h0);
    for (int i = 0; i < 4; i++) begin
      op(1'b1, 1'b1, 6'h03, 36'hF_1234_5678 ^ 36'(i), 4'(5 << i));
      op(1'b1, 1'b0, 6'h03, 36'h0, 4'h0);
    end
    // gate the clock with a write, then a read, still in flight
    for (int i = 0; i < 2; i++) begin
      op(1'b1, i == 0, 6'h30, 36'h9_0F0F_A55A, 4'h0);
      stall = 1'b1;
      idle(3);
      stall = 1'b0;
    end
    for (int m = 0; m < 2; m++) begin
      // order only changes between bursts
      idle(4);
      mode = m[0];
      // second pass keeps some lanes on every beat after the first, over words already written
      for (int b = 0; b < 5; b++) begin
        op(b == 0, b == 0, 6'h21, {4'(b), 32'hC0DE_0000 + 32'(16 * m + b)}, 4'(m * b));
      end
      for (int b = 0; b < 5; b++) op(b == 0, b != 0, 6'h22, 36'h0, 4'h0);
    end
    idle(8);
    sleep_want = 1'b1;
    idle(12);
    check(36'h1, {35'h0, asleep});
    sleep_want = 1'b0;
    idle(12);
    check(36'h0, {35'h0, asleep});
    for (int i = 0; i < 8; i++) op(1'b1, 1'b0, 6'(i), 36'h0, 4'h0);
    idle(8);
    rst_n = 1'b0;
    idle(3);
    check(36'h0, {35'h0, bus.dev_drive});
    rst_n = 1'b1;
    op(1'b1, 1'b0, 6'h05, 36'h0, 4'h0);
    idle(10);
    check(36'h0, 36'(exp_q.size()));
    print_verdict();
  end

  initial begin
    repeat (4000) @(posedge clk);
    failures++;
    print_verdict();
  end
endmodule : pbsp_tb
`default_nettype wire
